// ===== logic/option_clock_reset_consts.vh
`ifndef OPTION_CLOCK_RESET_CONSTS_VH
`define OPTION_CLOCK_RESET_CONSTS_VH

// Reset phase lengths in CPU cycles
`define RESET_CYCLES_LONG 13'h1000
`define RESET_CYCLES_SHORT 13'h0100

// Reset-length option encoding
`define RESET_LENGTH_LONG 1'b0

// Clock source codes
`define SRC_RESONATOR 2'h0
`define SRC_RESERVED 2'h1
`define SRC_INTERNAL_RC 2'h2
`define SRC_EXTERNAL 2'h3

// Range codes
`define RANGE_LOWEST 3'h0
`define RANGE_LOW_MID 3'h1
`define RANGE_HIGH_MID 3'h2
`define RANGE_HIGHEST 3'h3

// Multiplier disable encoding
`define MULT_ENABLED 1'b0

// Sequencer states
`define ST_RESET 2'h0
`define ST_RUN 2'h1
`define ST_HALT 2'h2
`define ST_WAKE 2'h3

`endif

// ===== logic/option_clock_reset_config.v
`timescale 1ns/1ns
`include "option_clock_reset_consts.vh"

// How it works
// - With the reset-length bit at 0 the reset phase lasts 4096 CPU cycles.
// - With the reset-length bit at 1 the reset phase lasts 256 CPU cycles.
// - The same cycle count is the stabilisation delay on leaving deep stop.
// - The source option selects resonator, internal RC or external; code 01 is reserved.
// - With the resonator, the range option sets the oscillator current source.
// - With other sources, the range option gives the nominal operating range.
// - The multiplier-disable bit at 0 doubles the input clock, at 1 bypasses it.
module option_clock_reset_config (
    input wire clk_in,
    input wire rst_n_in,
    input wire reset_length_select_in,
    input wire [1:0] clock_source_select_in,
    input wire [2:0] osc_frequency_range_in,
    input wire multiplier_disable_in,
    input wire low_voltage_detector_in,
    input wire readout_protect_in,
    input wire halt_request_in,
    input wire wakeup_in,
    output reg cpu_running_out,
    output reg halted_out,
    output reg [1:0] clock_source_out,
    output reg [2:0] osc_current_range_out,
    output reg [2:0] operating_range_out,
    output reg resonator_enable_out,
    output reg rc_enable_out,
    output reg external_enable_out,
    output reg multiplier_enable_out,
    output reg master_clock_divide_out,
    output reg config_error_out
);

    reg [1:0] state;
    reg [1:0] next_state;
    reg [12:0] count;
    reg [12:0] next_count;
    reg latched;
    reg long_reset;
    reg [12:0] phase_len;

    // Decoded option values ahead of capture
    reg next_long_reset;
    reg [1:0] next_clock_source;
    reg [2:0] next_osc_current_range;
    reg [2:0] next_operating_range;
    reg next_resonator_enable;
    reg next_rc_enable;
    reg next_external_enable;
    reg next_multiplier_enable;
    reg next_master_clock_divide;
    reg next_config_error;

    wire resonator_picked;
    wire [2:0] range_to_osc;
    wire [2:0] range_to_op;
    genvar i;

    // Match of a source code against one value
    function source_is;
        input [1:0] src;
        input [1:0] code;
        begin
            source_is = (src == code);
        end
    endfunction

    // Illegal option combination decode
    function bad_config;
        input [1:0] src;
        input [2:0] rng;
        input mult_off;
        input low_voltage_detector;
        input rop;
        begin
            bad_config = source_is(src, `SRC_RESERVED)
                || ((mult_off == `MULT_ENABLED) && (src != `SRC_RESONATOR))
                || ((mult_off == `MULT_ENABLED) && (rng != `RANGE_LOW_MID))
                || ((src == `SRC_INTERNAL_RC) && !low_voltage_detector)
                || (rop && low_voltage_detector)
                || (rng > `RANGE_HIGHEST);
        end
    endfunction

    assign resonator_picked = source_is(clock_source_select_in, `SRC_RESONATOR);

    // Range bits routed by source type
    generate
        for (i = 0; i < 3; i = i + 1) begin : route_range
            assign range_to_osc[i] = resonator_picked & osc_frequency_range_in[i];
            assign range_to_op[i] = !resonator_picked & osc_frequency_range_in[i];
        end
    endgenerate

    // Option decode
    always @* begin
        next_long_reset = (reset_length_select_in == `RESET_LENGTH_LONG);
        next_clock_source = clock_source_select_in;
        next_resonator_enable = resonator_picked;
        next_rc_enable = source_is(clock_source_select_in, `SRC_INTERNAL_RC);
        next_external_enable = source_is(clock_source_select_in, `SRC_EXTERNAL);
        next_osc_current_range = range_to_osc;
        next_operating_range = range_to_op;
        next_multiplier_enable = (multiplier_disable_in == `MULT_ENABLED);
        next_master_clock_divide = (multiplier_disable_in != `MULT_ENABLED);
        next_config_error = bad_config(clock_source_select_in, osc_frequency_range_in,
            multiplier_disable_in, low_voltage_detector_in, readout_protect_in);
    end

    // Phase length from the captured option
    always @* begin
        if (long_reset) begin
            phase_len = `RESET_CYCLES_LONG;
        end else begin
            phase_len = `RESET_CYCLES_SHORT;
        end
    end

    always @* begin
        next_state = state;
        next_count = count;
        case (state)
            `ST_RESET: begin
                if (count >= phase_len - 13'h0001) begin
                    next_state = `ST_RUN;
                    next_count = 13'h0000;
                end else begin
                    next_count = count + 13'h0001;
                end
            end
            `ST_RUN: begin
                if (halt_request_in) begin
                    next_state = `ST_HALT;
                end
            end
            `ST_HALT: begin
                if (wakeup_in) begin
                    next_state = `ST_WAKE;
                    next_count = 13'h0000;
                end
            end
            `ST_WAKE: begin
                if (count >= phase_len - 13'h0001) begin
                    next_state = `ST_RUN;
                    next_count = 13'h0000;
                end else begin
                    next_count = count + 13'h0001;
                end
            end
            default: begin
                next_state = `ST_RESET;
                next_count = 13'h0000;
            end
        endcase
    end

    // Options captured on the first clock after reset release
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            latched <= 1'b0;
            long_reset <= 1'b1;
            clock_source_out <= 2'h0;
            osc_current_range_out <= 3'h0;
            operating_range_out <= 3'h0;
            resonator_enable_out <= 1'b0;
            rc_enable_out <= 1'b0;
            external_enable_out <= 1'b0;
            multiplier_enable_out <= 1'b0;
            master_clock_divide_out <= 1'b1;
            config_error_out <= 1'b0;
        end else if (!latched) begin
            latched <= 1'b1;
            long_reset <= next_long_reset;
            clock_source_out <= next_clock_source;
            resonator_enable_out <= next_resonator_enable;
            rc_enable_out <= next_rc_enable;
            external_enable_out <= next_external_enable;
            osc_current_range_out <= next_osc_current_range;
            operating_range_out <= next_operating_range;
            multiplier_enable_out <= next_multiplier_enable;
            master_clock_divide_out <= next_master_clock_divide;
            config_error_out <= next_config_error;
        end
    end

    // Reset phase and halt-exit sequencing
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= `ST_RESET;
            count <= 13'h0000;
            cpu_running_out <= 1'b0;
            halted_out <= 1'b0;
        end else if (!latched) begin
            state <= `ST_RESET;
            count <= 13'h0000;
            cpu_running_out <= 1'b0;
            halted_out <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            cpu_running_out <= (next_state == `ST_RUN);
            halted_out <= (next_state == `ST_HALT);
        end
    end

endmodule

// ===== tb/option_clock_reset_checker.sv
`timescale 1ns/1ns
module option_clock_reset_checker (
    input wire clk_in,
    input wire rst_n_in,
    input wire reset_length_select_in,
    input wire halt_request_in,
    input wire wakeup_in,
    input wire cpu_running_out,
    input wire halted_out,
    input wire [1:0] clock_source_out,
    input wire [2:0] osc_current_range_out,
    input wire [2:0] operating_range_out,
    input wire resonator_enable_out,
    input wire rc_enable_out,
    input wire external_enable_out,
    input wire multiplier_enable_out,
    input wire master_clock_divide_out,
    input wire config_error_out
);
    int cnt;
    logic len, cap, first;
    wire [12:0] n_len = len ? 13'h0100 : 13'h1000;
    // Cycles spent neither running nor halted
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= 0;
            cap <= 1'b0;
            len <= 1'b0;
            first <= 1'b1;
        end else begin
            cnt <= (cpu_running_out || halted_out) ? 0 : cnt + 1;
            cap <= 1'b1;
            first <= first && !cpu_running_out;
            if (!cap) len <= reset_length_select_in;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    chk_reset_phase: assert property (
        $rose(cpu_running_out) && first |-> cnt == n_len + 1)
        else $error("Reset phase length wrong");
    chk_wake_delay: assert property ($rose(cpu_running_out) && !first |-> cnt == n_len)
        else $error("Wake delay length wrong");
    chk_halt_enter: assert property (
        cpu_running_out && halt_request_in |=> halted_out && !cpu_running_out)
        else $error("Halt not entered");
    chk_halt_hold: assert property (halted_out && !wakeup_in |=> halted_out)
        else $error("Halt left without wakeup");
    chk_wake_exit: assert property (
        halted_out && wakeup_in |=> (!halted_out && !cpu_running_out) [*3])
        else $error("Wake exit wrong");
    chk_opt_stable: assert property (
        cpu_running_out |-> $stable({clock_source_out, osc_current_range_out, config_error_out}))
        else $error("Options changed while running");
    chk_src_decode: assert property (
        cpu_running_out |-> {resonator_enable_out, rc_enable_out, external_enable_out} ==
        {clock_source_out == 2'h0, clock_source_out == 2'h2, clock_source_out == 2'h3})
        else $error("Source decode wrong");
    chk_range_route: assert property (
        cpu_running_out |->
        (resonator_enable_out ? operating_range_out : osc_current_range_out) == 3'h0)
        else $error("Range routed wrong");
    chk_clock_div: assert property (master_clock_divide_out != multiplier_enable_out)
        else $error("Divide and doubler disagree");
    chk_reserved_err: assert property (
        cpu_running_out && clock_source_out == 2'h1 |-> config_error_out)
        else $error("Reserved source not flagged");
    cov_wake: cover property ($rose(cpu_running_out) && !first);
    cov_halt: cover property (cpu_running_out && halt_request_in);
    cov_error: cover property (cpu_running_out && config_error_out);
endmodule
bind option_clock_reset_config option_clock_reset_checker option_clock_reset_checker_inst (.*);

// ===== tb/option_clock_reset_config_test.sv
`timescale 1ns/1ns
module option_clock_reset_config_test;
    logic clk_in = 0, rst_n_in = 0, reset_length_select_in = 0, multiplier_disable_in = 1;
    logic low_voltage_detector_in = 0, readout_protect_in = 0, halt_request_in = 0, wakeup_in = 0;
    logic [1:0] clock_source_select_in = 2'h0;
    logic [2:0] osc_frequency_range_in = 3'h0;
    logic cpu_running_out, halted_out, resonator_enable_out, rc_enable_out, external_enable_out;
    logic multiplier_enable_out, master_clock_divide_out, config_error_out;
    logic [1:0] clock_source_out;
    logic [2:0] osc_current_range_out, operating_range_out;
    // First entry is a legal resonator set with long reset and doubler at 2~4MHz
    logic [8:0] cfg [6] = '{9'h008, 9'h154, 9'h19e, 9'h180, 9'h1e7, 9'h110};
    int err_count = 0, tests_run = 0;
    option_clock_reset_config option_clock_reset_config_inst (.*);
    always #50 clk_in = ~clk_in;
    task check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Counts edges until running, bounded
    task wait_run(output int n);
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            #5;
        end while (cpu_running_out !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            err_count++;
            complete_run;
        end
    endtask
    task boot(input logic [8:0] o);
        int n;
        logic res, err;
        rst_n_in = 0;
        {reset_length_select_in, clock_source_select_in, osc_frequency_range_in} = o[8:3];
        {multiplier_disable_in, low_voltage_detector_in, readout_protect_in} = o[2:0];
        repeat (5) @(posedge clk_in);
        #5 rst_n_in = 1;
        wait_run(n);
        check(n, o[8] ? 257 : 4097);
        {reset_length_select_in, clock_source_select_in, osc_frequency_range_in} = ~o[8:3];
        multiplier_disable_in = ~o[2];
        res = o[7:6] == 2'h0;
        err = o[7:6] == 2'h1 || (!o[2] && (!res || o[5:3] != 3'h1));
        err = err || (o[7:6] == 2'h2 && !o[1]) || (o[0] && o[1]) || o[5:3] > 3'h3;
        @(posedge clk_in);
        #5;
        check({clock_source_out, osc_current_range_out, operating_range_out, resonator_enable_out,
            rc_enable_out, external_enable_out, multiplier_enable_out, master_clock_divide_out,
            config_error_out}, {o[7:6], res ? o[5:3] : 3'h0, res ? 3'h0 : o[5:3], res,
            o[7:6] == 2'h2, o[7:6] == 2'h3, !o[2], o[2], err});
        halt_request_in = 1;
        @(posedge clk_in);
        #5 halt_request_in = 0;
        check({halted_out, cpu_running_out}, 2'h2);
        wakeup_in = 1;
        @(posedge clk_in);
        #5 wakeup_in = 0;
        check(halted_out, 1'b0);
        wait_run(n);
        check(n, o[8] ? 256 : 4096);
        $display("Test done for options %h", o);
    endtask
    initial begin
        for (int i = 0; i < 6; i++) boot(cfg[i]);
        complete_run;
    end
endmodule
